/* rtl/tws_top.sv */
/*
  Two-wire serial slave giving a bus master read and write access to
  a 16-bit register map, single or auto-incrementing.
  Assumes an external pull-up on the data line, a bus clock no faster
  than about a quarter of mclk_i, and a master that keeps data stable
  while the bus clock is high except for start and stop.
*/
// Functional notes
// [RL1] Slave only: bus clock is an input, data line is bidirectional.
// [RL2] A one on the data line is sent by releasing it, never driving.
// [RL3] Master starts a transfer: data falls while clock is high.
// [RL4] After start, shift in eight bits MSB first: ID then R/W.
// [RL5] Last bit of first byte: one means read, zero means write.
// [RL6] Compare received 7-bit ID with own fixed ID.
// [RL7] On ID match, pull data low during the ninth clock pulse.
// [RL8] ID mismatch or read in write-only mode: go idle, no ACK.
// [RL9] Master ends a transfer: data rises while clock is high.
// [RL10] After a complete sequence return to idle for next start.
// [RL11] Misplaced start or stop mid-transfer abandons it, go idle.
// [RL12] An 8-bit register address follows the ID byte.
// [RL13] Every register reads back, chip code and power status too.
// [RL14] Single and multi-register access with auto-incrementing index.
// [RL15] NACK leaves data high on the ninth clock; ACK drives low.
// [RL16] Registers are 16 bits as two bytes, MSB first, each ACKed.
// [RL17] Reads: write address, repeated start, ACK all but last byte.
`timescale 1ns/1ps
`include "tws_map.svh"

module tws_top
  import tws_pkg::*;
#(
  // Own bus address; value is arbitrary
  parameter logic [6:0] DEV_ID = 7'h2A
)
(
  // System clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Bus clock from the master
  input wire logic scl_i,
  // Open-drain data line
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Mode and status
  input wire logic write_only_i,
  input wire logic [15:0] pm_status_i,
  // Register write notification
  output logic wr_stb_o,
  output logic [7:0] wr_addr_o,
  output logic [15:0] wr_data_o,
  // Transfer in progress
  output logic busy_o
);

  tws_top_st_t r;
  tws_top_st_t n;

  tws_bit_if bit_if ();
  tws_reg_if reg_if ();

  logic scl_hi;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic bit_evt;
  logic b;
  logic [7:0] rx_byte;
  logic id_ok;
  logic rd_ok;

  // Bus clock is only ever sampled, never driven
  tws_link u_link ( // [RL1]
    .scl_clk_i(scl_i),
    .rst_i(rst_i),
    .sda_i(sda_i),
    .bit_o(bit_if)
  );

  tws_regfile u_regs (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .pm_status_i(pm_status_i),
    .bus_i(reg_if)
  );

  assign reg_if.we = r.wr_stb;
  assign reg_if.waddr = r.wr_addr;
  assign reg_if.wdata = r.wr_data;
  assign reg_if.raddr = r.addr;

  always_comb
  begin
    n = r;
    // Bit 0 clock, bit 1 data, bit 2 link toggle; s1 feeds s2 only
    n.s1 = {bit_if.tgl, sda_i, scl_i};
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.wr_stb = 1'b0;

    scl_hi = r.s2[0] & r.s3[0];
    scl_fall = r.s3[0] & ~r.s2[0];
    start_det = scl_hi & r.s3[1] & ~r.s2[1]; // [RL3]
    stop_det = scl_hi & ~r.s3[1] & r.s2[1]; // [RL9]
    // The captured bit is held until the next rising edge, long after
    // its toggle has crossed, so it is read here without a synchroniser
    bit_evt = r.s2[2] ^ r.s3[2];
    b = bit_if.bit_val;
    rx_byte = {r.sh[6:0], b}; // [RL4]
    id_ok = (rx_byte[7:1] == DEV_ID); // [RL6]
    rd_ok = ~(rx_byte[0] & write_only_i); // [RL5] [RL8]

    if (start_det)
    begin
      // Legal only at a byte boundary; a repeated start's clock rise
      // has already counted as one bit, so that count is accepted too
      if ((r.st == ST_IDLE) || (r.cnt == `TWS_BIT_FIRST) ||
          (r.cnt == `TWS_BIT_SETUP))
        n.st = ST_DEVID; // [RL4]
      else
        n.st = ST_IDLE; // [RL11]
      n.cnt = `TWS_BIT_FIRST;
      n.oe = 1'b0;
      n.hi_done = 1'b0;
      n.byte_sel = 1'b0;
      n.ack = 1'b0;
    end
    else if (stop_det)
    begin
      // Half a register pair left pending is dropped here
      n.st = ST_IDLE; // [RL10] [RL11]
      n.cnt = `TWS_BIT_FIRST;
      n.oe = 1'b0;
      n.hi_done = 1'b0;
      n.ack = 1'b0;
    end
    else
    begin
      if (bit_evt && (r.st != ST_IDLE))
      begin
        if (r.cnt == `TWS_BIT_ACK)
          n.cnt = `TWS_BIT_FIRST;
        else
          n.cnt = 4'(r.cnt + 4'h1);

        if (tws_is_rx(r.st))
        begin
          if (r.cnt != `TWS_BIT_ACK)
            n.sh = rx_byte;
          if (r.cnt == `TWS_BIT_LAST)
          begin
            case (r.st)
              ST_DEVID:
              begin
                n.rw = rx_byte[0]; // [RL5]
                if (id_ok && rd_ok)
                  n.ack = 1'b1; // [RL7]
                else
                begin
                  n.ack = 1'b0;
                  n.st = ST_IDLE; // [RL8]
                  n.cnt = `TWS_BIT_FIRST;
                end
              end
              ST_REGADR:
              begin
                n.addr = rx_byte; // [RL12]
                n.hi_done = 1'b0;
                n.ack = 1'b1;
              end
              ST_WRDATA:
              begin
                n.ack = 1'b1; // [RL16]
                if (!r.hi_done)
                begin
                  n.msb = rx_byte; // [RL16]
                  n.hi_done = 1'b1;
                end
                else
                begin
                  n.wr_stb = 1'b1;
                  n.wr_addr = r.addr;
                  n.wr_data = {r.msb, rx_byte}; // [RL16]
                  n.addr = 8'(r.addr + 8'h01); // [RL14]
                  n.hi_done = 1'b0;
                end
              end
              default:
              begin
                n.ack = 1'b0;
              end
            endcase
          end
          else if (r.cnt == `TWS_BIT_ACK)
          begin
            case (r.st)
              ST_DEVID:
              begin
                if (r.rw)
                begin
                  // Read continues from the last address used
                  n.st = ST_RDDATA; // [RL17]
                  n.sh = reg_if.rdata[15:8]; // [RL16]
                  n.lo = reg_if.rdata[7:0];
                  n.byte_sel = 1'b0;
                end
                else
                  n.st = ST_REGADR; // [RL12]
              end
              ST_REGADR:
              begin
                n.st = ST_WRDATA;
              end
              ST_WRDATA:
              begin
                n.st = ST_WRDATA; // [RL14]
              end
              default:
              begin
                n.st = ST_IDLE;
              end
            endcase
          end
        end
        else if (r.st == ST_RDDATA)
        begin
          if (r.cnt != `TWS_BIT_ACK)
            n.sh = {r.sh[6:0], 1'b0};
          else if (b)
          begin
            // Master NACK ends the read; wait for stop or start
            n.st = ST_IDLE; // [RL15] [RL17]
            n.cnt = `TWS_BIT_FIRST;
          end
          else if (!r.byte_sel)
          begin
            n.sh = r.lo; // [RL16]
            n.byte_sel = 1'b1;
            n.addr = 8'(r.addr + 8'h01); // [RL14]
          end
          else
          begin
            n.sh = reg_if.rdata[15:8]; // [RL14] [RL16]
            n.lo = reg_if.rdata[7:0];
            n.byte_sel = 1'b0;
          end
        end
      end

      // The line only changes after the clock falls
      if (scl_fall)
      begin
        case (r.st)
          ST_RDDATA:
          begin
            // Zero pulls low, one releases; ninth bit left to master
            n.oe = (r.cnt != `TWS_BIT_ACK) & ~r.sh[7]; // [RL2] [RL15]
          end
          ST_DEVID, ST_REGADR, ST_WRDATA:
          begin
            n.oe = (r.cnt == `TWS_BIT_ACK) & r.ack; // [RL7] [RL15]
          end
          default:
          begin
            n.oe = 1'b0;
          end
        endcase
      end
    end

    n.busy = (n.st != ST_IDLE);
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.st <= ST_IDLE;
    end
    else
      r <= n;
  end

  // Pad value is always low; only the enable moves
  assign sda_o = 1'b0; // [RL2]
  assign sda_oe_o = r.oe;
  assign wr_stb_o = r.wr_stb;
  assign wr_addr_o = r.wr_addr;
  assign wr_data_o = r.wr_data;
  assign busy_o = r.busy;

endmodule // tws_top

/* rtl/tws_map.svh */
/*
  Constants of the two-wire register slave: register indices, reset
  values and bit counts of the serial frame.
  Assumes it is included by bare name; the guard makes repeated inclusion harmless.
*/
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH

// Register indices inside the 16-word map
`define TWS_IDX_CHIP_ID 4'h0
`define TWS_IDX_PM_STAT 4'h1
`define TWS_IDX_BITS 4
`define TWS_PAGE_ZERO 4'h0

// Reset value of every writable word
`define TWS_REG_RST 16'h0000

// Bit counter positions within a nine-bit byte frame
`define TWS_BIT_FIRST 4'h0
`define TWS_BIT_SETUP 4'h1
`define TWS_BIT_LAST 4'h7
`define TWS_BIT_ACK 4'h8

`endif

/* rtl/tws_pkg.sv */
/*
  Types of the two-wire register slave: protocol states, the state
  structs of each module and a shared state decoder.
  Assumes nothing of its surroundings.
*/
package tws_pkg;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_DEVID  = 5'h02,
    ST_REGADR = 5'h04,
    ST_WRDATA = 5'h08,
    ST_RDDATA = 5'h10
  } tws_state_t;

  typedef struct packed {
    logic bit_val;
    logic tgl;
  } tws_link_st_t;

  typedef struct packed {
    logic [15:0][15:0] mem;
  } tws_rf_st_t;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    tws_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic ack;
    logic rw;
    logic [7:0] addr;
    logic [7:0] msb;
    logic [7:0] lo;
    logic hi_done;
    logic byte_sel;
    logic oe;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [15:0] wr_data;
    logic busy;
  } tws_top_st_t;

  // States in which the device receives bytes and answers with ACK
  function automatic logic tws_is_rx(input tws_state_t s);
    tws_is_rx = (s == ST_DEVID) || (s == ST_REGADR) || (s == ST_WRDATA);
  endfunction

endpackage

/* rtl/tws_if.sv */
/*
  Carriers between the modules of the two-wire register slave: the
  captured bit from the link domain and the register file port.
  Assumes instantiation inside the top module only.
*/
`timescale 1ns/1ps

interface tws_bit_if;
  logic bit_val;
  logic tgl;
  modport src (output bit_val, output tgl);
  modport dst (input bit_val, input tgl);
endinterface

interface tws_reg_if;
  logic we;
  logic [7:0] waddr;
  logic [15:0] wdata;
  logic [7:0] raddr;
  logic [15:0] rdata;
  modport master (output we, output waddr, output wdata, output raddr,
                  input rdata);
  modport slave (input we, input waddr, input wdata, input raddr,
                 output rdata);
endinterface

/* rtl/tws_link.sv */
/*
  Link-domain capture of the serial data line on each rising clock
  edge, with a toggle that marks every new bit.
  Assumes the bus clock is its clock and stands still between frames;
  the bit value stays put until the next rising edge.
*/
`timescale 1ns/1ps

module tws_link
  import tws_pkg::*;
(
  // Link clock and reset
  input wire logic scl_clk_i,
  input wire logic rst_i,
  // Data pin
  input wire logic sda_i,
  // Captured bit towards the system domain
  tws_bit_if.src bit_o
);

  tws_link_st_t r;
  tws_link_st_t n;

  always_comb
  begin
    n = r;
    n.bit_val = sda_i; // [RL4]
    n.tgl = ~r.tgl;
  end

  always_ff @(posedge scl_clk_i or posedge rst_i)
  begin
    if (rst_i)
      r <= '0;
    else
      r <= n;
  end

  assign bit_o.bit_val = r.bit_val;
  assign bit_o.tgl = r.tgl;

endmodule // tws_link

/* rtl/tws_regfile.sv */
/*
  Sixteen-word register map of 16-bit values with one write port and
  one combinational read port; word 0 is the chip code, word 1 shows
  the power status input, both read only.
  Assumes writes arrive as one-cycle strobes from the same clock.
*/
`timescale 1ns/1ps
`include "tws_map.svh"

module tws_regfile
  import tws_pkg::*;
#(
  // Chip code value is arbitrary
  parameter logic [15:0] CHIP_ID = 16'h5A01
)
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Status shown in the map
  input wire logic [15:0] pm_status_i,
  // Register port
  tws_reg_if.slave bus_i
);

  tws_rf_st_t r;
  tws_rf_st_t n;
  logic [15:0] wen;
  logic [15:0] rd;

  function automatic logic in_map(input logic [7:0] a);
    in_map = (a[7:4] == `TWS_PAGE_ZERO);
  endfunction

  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : g_wen
      assign wen[g] = bus_i.we && in_map(bus_i.waddr) &&
                      (bus_i.waddr[3:0] == 4'(g)) &&
                      (4'(g) != `TWS_IDX_CHIP_ID) &&
                      (4'(g) != `TWS_IDX_PM_STAT);
    end
  endgenerate

  always_comb
  begin
    n = r;
    for (int i = 0; i < 16; i++)
    begin
      if (wen[i])
        n.mem[i] = bus_i.wdata;
    end
  end

  // Every word reads back, including chip code and power status
  always_comb
  begin
    rd = 16'h0000;
    if (in_map(bus_i.raddr))
    begin
      case (bus_i.raddr[3:0])
        `TWS_IDX_CHIP_ID: rd = CHIP_ID; // [RL13]
        `TWS_IDX_PM_STAT: rd = pm_status_i; // [RL13]
        default: rd = r.mem[bus_i.raddr[3:0]]; // [RL13]
      endcase
    end
  end

  assign bus_i.rdata = rd;

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      r <= {16{`TWS_REG_RST}};
    else
      r <= n;
  end

endmodule // tws_regfile

/* verification/tws_master.sv */
/*
  Bus master model: drives the bus clock at a 48 ns bit period and the
  data line open drain (1 = released).
  Assumes a pull-up that the bench resolves with the slave's pull-down.
*/
`timescale 1ns/1ps

module tws_master
(
  // Bus pins
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  localparam time Q = 12;

  // Clock stands high between frames, data released
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Data set mid low phase, sampled mid high phase
  task automatic clk_bit(input logic b, output logic r);
    #Q sda_o = b;
    #Q scl_o = 1'b1;
    #Q r = sda_i;
    #Q scl_o = 1'b0;
  endtask

  // Wide gaps so the synchronised copies see the order
  task automatic start();
    #Q sda_o = 1'b1;
    #(2*Q) scl_o = 1'b1;
    #(2*Q) sda_o = 1'b0;
    #(2*Q) scl_o = 1'b0;
  endtask

  task automatic stop();
    #Q sda_o = 1'b0;
    #(2*Q) scl_o = 1'b1;
    #(2*Q) sda_o = 1'b1;
    #(2*Q);
  endtask

  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, r);
    ack = ~r;
  endtask

  // Last byte of a read gets a NACK
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++)
    begin
      clk_bit(1'b1, r);
      d = {d[6:0], r};
    end
    clk_bit(last, r);
  endtask
endmodule // tws_master

/* verification/tws_top_asserts.sv */
/*
  Protocol checks of the two-wire register slave.
  Assumes it is bound to tws_top and sees only its ports.
*/
`timescale 1ns/1ps

module tws_top_asserts
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // Write notification and status
  input wire logic wr_stb_o,
  input wire logic [7:0] wr_addr_o,
  input wire logic [15:0] wr_data_o,
  input wire logic busy_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence bus_start;
    scl_i && $fell(sda_i);
  endsequence

  sequence bus_stop;
    scl_i && $rose(sda_i);
  endsequence

  a_never_drive_high: assert property (sda_oe_o |-> !sda_o)
    else $error("data driven high");
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data changed while bus clock high");
  a_oe_holds: assert property ($rose(sda_oe_o) |-> sda_oe_o [*6])
    else $error("pull-down too short");
  // Misplaced starts idle the slave, so only idle starts are checked
  a_start_busy: assert property (bus_start ##1 !busy_o |->
    ##[1:8] busy_o)
    else $error("start not taken");
  a_stop_idles: assert property (bus_stop |-> ##[1:8] !busy_o)
    else $error("stop did not idle");
  a_idle_release: assert property (!busy_o ##1 !busy_o |->
    !sda_oe_o)
    else $error("idle slave pulls data");
  a_stb_pulse: assert property (wr_stb_o |=> !wr_stb_o)
    else $error("write strobe too long");
  a_stb_busy: assert property (wr_stb_o |-> busy_o)
    else $error("write outside transfer");
  a_wr_stable: assert property (!wr_stb_o |->
    $stable(wr_addr_o) && $stable(wr_data_o))
    else $error("write outputs moved without strobe");
endmodule // tws_top_asserts

bind tws_top tws_top_asserts tws_top_asserts_i (.mclk_i, .rst_i, .scl_i,
  .sda_i, .sda_o, .sda_oe_o, .wr_stb_o, .wr_addr_o, .wr_data_o, .busy_o);

/* verification/tws_top_tb_top.sv */
/*
  Self-checking bench of the two-wire register slave with a master model.
  Assumes the design's default device and chip codes.
*/
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin miscompares++; $display("FAIL %s exp %0h got %0h", n, e, s); end end

module tws_top_tb_top;
  localparam logic [6:0] ID = 7'h2A; // Arbitrary, design default
  localparam logic [15:0] CHIP = 16'h5A01; // Arbitrary chip code
  logic mclk = 0, rst, scl, sda_m, sda, sda_o, sda_oe, wo, stb, busy, ak;
  logic [15:0] pm, wdat, got;
  logic [7:0] wadr, b, ix;
  logic [31:0] seed = 32'd3479;
  logic [15:0] mem [16];
  int miscompares, checks_done;

  always #2.5 mclk = ~mclk;
  // Pull-up wins unless either side pulls low
  assign sda = sda_m & ~(sda_oe & ~sda_o);

  tws_top tws_top_i (.mclk_i(mclk), .rst_i(rst), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .write_only_i(wo), .pm_status_i(pm),
    .wr_stb_o(stb), .wr_addr_o(wadr), .wr_data_o(wdat), .busy_o(busy));
  tws_master tws_master_i (.scl_o(scl), .sda_o(sda_m), .sda_i(sda));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] expv(input int i);
    return i == 0 ? CHIP : i == 1 ? pm : i > 15 ? 16'h0000 : mem[i];
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic hdr(input logic [7:0] idx);
    tws_master_i.start();
    tws_master_i.put({ID, 1'b0}, ak); `CHK("id ack", 1'b1, ak)
    tws_master_i.put(idx, ak); `CHK("adr ack", 1'b1, ak)
  endtask

  task automatic wr(input logic [7:0] idx, input int n);
    logic [15:0] v;
    hdr(idx);
    for (int k = 0; k < n; k++)
    begin
      v = 16'(rnd());
      tws_master_i.put(v[15:8], ak); `CHK("msb ack", 1'b1, ak)
      tws_master_i.put(v[7:0], ak); `CHK("lsb ack", 1'b1, ak)
      if (idx + k > 1 && idx + k < 16) mem[idx + k] = v;
      `CHK("wr addr", 8'(idx + k), wadr)
      `CHK("wr data", v, wdat)
    end
    tws_master_i.stop();
  endtask

  task automatic rd(input logic [7:0] idx, input int n);
    hdr(idx);
    tws_master_i.start();
    tws_master_i.put({ID, 1'b1}, ak); `CHK("rd ack", 1'b1, ak)
    for (int k = 0; k < 2 * n; k++)
    begin
      tws_master_i.get(k == 2 * n - 1, b);
      got = {got[7:0], b};
      if (k % 2) `CHK("rd data", expv(idx + k / 2), got)
    end
    tws_master_i.stop();
  endtask

  task automatic refuse(input logic [7:0] first);
    tws_master_i.start();
    tws_master_i.put(first, ak); `CHK("nack", 1'b0, ak)
    `CHK("idle", 1'b0, busy)
    tws_master_i.put(8'h00, ak); `CHK("ignored", 1'b0, ak)
    tws_master_i.stop();
  endtask

  initial
  begin
    rst = 1'b1;
    wo = 1'b0;
    pm = 16'h0000;
    foreach (mem[i]) mem[i] = 16'h0000;
    repeat (3) @(posedge mclk);
    #1 rst = 1'b0;
    repeat (6) @(posedge mclk);
    `CHK("rst busy", 1'b0, busy)
    `CHK("rst data", 16'h0000, wdat)
    for (int t = 0; t < 6; t++)
    begin
      @(posedge mclk) #1 pm = 16'(rnd());
      ix = 8'(2 + rnd() % 13);
      wr(ix, 2);
      rd(ix, 2);
    end
    wr(8'h0F, 2);
    rd(8'h00, 2);
    rd(8'h0E, 3);
    // Start mid byte after a pending MSB: nothing may be stored
    hdr(8'h03);
    tws_master_i.put(8'hFF, ak);
    repeat (3) tws_master_i.clk_bit(1'b0, ak);
    tws_master_i.start();
    repeat (8) @(posedge mclk);
    `CHK("abandon", 1'b0, busy)
    tws_master_i.stop();
    rd(8'h03, 1);
    @(posedge mclk) #1 wo = 1'b1;
    refuse({ID, 1'b1});
    @(posedge mclk) #1 wo = 1'b0;
    refuse({~ID, 1'b0});
    report_and_stop();
  end

  // Whole run needs about 53 us
  initial
  begin
    #300us;
    miscompares++;
    report_and_stop();
  end
endmodule // tws_top_tb_top
